/* common/sdt_params.svh */
// Register map, field positions and fixed values of the single data transfer unit
`ifndef SDT_PARAMS_SVH
`define SDT_PARAMS_SVH

`define SDT_OFS_CTRL 8'h00
`define SDT_OFS_INSTR 8'h04
`define SDT_OFS_FLAGS 8'h08
`define SDT_OFS_BASE 8'h0C
`define SDT_OFS_OFFSET 8'h10
`define SDT_OFS_SRC 8'h14
`define SDT_OFS_PC 8'h18
`define SDT_OFS_STATUS 8'h1C
`define SDT_OFS_RESULT 8'h20
`define SDT_OFS_NEWBASE 8'h24
`define SDT_OFS_ADDR 8'h28
`define SDT_OFS_CYCLES 8'h2C

`define SDT_CTRL_START 0
`define SDT_CTRL_ENDIAN 1
`define SDT_CTRL_PRIV 2

`define SDT_ST_BUSY 0
`define SDT_ST_DONE 1
`define SDT_ST_ABORT 2
`define SDT_ST_SKIP 3
`define SDT_ST_ILLEGAL 4
`define SDT_ST_WBACK 5
`define SDT_ST_USER 6

`define SDT_PC_REG 4'hF
`define SDT_PC_BASE_ADD 32'h0000_0008
`define SDT_PC_STORE_ADD 32'h0000_000C

`define SDT_CYC_LOAD 4'h3
`define SDT_CYC_LOAD_PC 4'h5
`define SDT_CYC_STORE 4'h2

`endif

/* common/sdt_pkg.sv */
// Types shared by the single data transfer unit
package sdt_pkg;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_N = 2'b01,
    CYC_S = 2'b10,
    CYC_I = 2'b11
  } sdt_cyc_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XFER = 3'b001,
    ST_STN = 3'b010,
    ST_INT = 3'b011,
    ST_REFN = 3'b100,
    ST_REFS = 3'b101,
    ST_SEQ = 3'b110
  } sdt_state_t;

  typedef struct packed {
    logic req;
    logic write;
    logic byte_sel;
    logic user;
    sdt_cyc_t cyc;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sdt_mem_t;

  typedef struct packed {
    logic [3:0] cond;
    logic [1:0] cls;
    logic reg_off;
    logic pre;
    logic up;
    logic byte_sel;
    logic wback;
    logic load;
    logic [3:0] rn;
    logic [3:0] rd;
    logic [11:0] off;
  } sdt_instr_t;

endpackage

/* rtl/sdt_unit.sv */
// Single word/byte load and store execution unit with an AHB-Lite register port
//
// Functional notes
// - Execute only when condition passes
// - Offset from 12-bit immediate or register
// - Direction bit set adds, clear subtracts
// - Pre-index uses modified base, post uses base
// - Pre-index writes back only when requested
// - Post-index always writes back modified base
// - Privileged post-index with write-back goes user
// - Immediate shifts only, no register shift amounts
// - Size bit picks byte or word
// - Endian select steers byte lane placement
// - Little endian byte from low lanes
// - Big endian byte from high lanes
// - Byte store replicates byte on all lanes
// - Little endian word load rotates addressed byte low
// - Big endian word load rotation by offset
// - Word store drives register unrotated
// - Program counter base reads as current plus 8
// - Program counter stored as current plus 12
// - Memory fault input raises data abort
// - Load 1S1N1I, PC load 2S2N1I, store 2N
`timescale 1ns/1ps
`include "sdt_params.svh"

module sdt_unit (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory side
  output sdt_pkg::sdt_mem_t mem_out,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_abort,
  output logic data_abort
);
  import sdt_pkg::*;

  sdt_state_t state_reg;
  sdt_mem_t mem_reg;
  sdt_instr_t ins;
  logic [2:0] ctrl_reg;
  logic [31:0] instr_reg;
  logic [3:0] flags_reg;
  logic [31:0] base_val_reg;
  logic [31:0] offset_val_reg;
  logic [31:0] src_reg;
  logic [31:0] pc_reg;
  logic [31:0] result_reg;
  logic [31:0] newbase_reg;
  logic [31:0] xaddr_reg;
  logic [3:0] cycles_reg;
  logic [3:0] cnt_reg;
  logic [6:0] status_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic abort_pulse_reg;
  logic pc_dest_reg;
  logic load_reg;
  logic byte_reg;
  logic aborted_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic cond_pass(logic [3:0] c, logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    logic r;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    case (c[3:1])
      3'h0: r = z;
      3'h1: r = cy;
      3'h2: r = n;
      3'h3: r = v;
      3'h4: r = cy & ~z;
      3'h5: r = (n == v);
      3'h6: r = ~z & (n == v);
      default: r = 1'b1;
    endcase
    if (c == 4'hF)
      r = 1'b0;
    else if (c != 4'hE)
      r = r ^ c[0];
    return r;
  endfunction

  function automatic logic [31:0] shift_off(logic [31:0] v, logic [4:0] amt,
                                            logic [1:0] typ, logic c);
    logic [31:0] r;
    case (typ)
      2'h0: r = v << amt;
      2'h1: r = (amt == 5'h00) ? 32'h0000_0000 : v >> amt;
      2'h2: r = (amt == 5'h00) ? {32{v[31]}} : 32'($signed(v) >>> amt);
      default: r = (amt == 5'h00) ? {c, v[31:1]} :
                   ((v >> amt) | (v << (6'd32 - {1'b0, amt})));
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Effective address

  logic [31:0] base_eff;
  logic [31:0] off_eff;
  logic [31:0] modified;
  logic [31:0] xfer_addr;
  logic [31:0] store_word;
  logic [31:0] store_data;
  logic wb_req;
  logic user_req;
  logic illegal;
  logic go;

  assign ins = sdt_instr_t'(instr_reg);
  assign base_eff = (ins.rn == `SDT_PC_REG) ? pc_reg + `SDT_PC_BASE_ADD
                                            : base_val_reg;
  // Register shift amounts are not decoded here, such an encoding is refused
  assign illegal = ins.reg_off & ins.off[4];
  assign off_eff = ins.reg_off ? shift_off(offset_val_reg, ins.off[11:7], ins.off[6:5],
                                           flags_reg[1])
                               : {20'h00000, ins.off};
  assign modified = ins.up ? base_eff + off_eff : base_eff - off_eff;
  assign xfer_addr = ins.pre ? modified : base_eff;
  assign wb_req = ~ins.pre | ins.wback;
  assign user_req = ~ins.pre & ins.wback & ctrl_reg[`SDT_CTRL_PRIV];
  assign store_word = (ins.rd == `SDT_PC_REG) ? pc_reg + `SDT_PC_STORE_ADD
                                              : src_reg;
  assign store_data = ins.byte_sel ? {4{store_word[7:0]}} : store_word;
  assign go = wr_pend_reg & (wr_addr_reg == `SDT_OFS_CTRL)
              & hwdata[`SDT_CTRL_START] & (state_reg == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Load data alignment

  logic [1:0] lane_ofs;
  logic [4:0] rot_amt;
  logic [31:0] rotated;
  logic [1:0] byte_lane;
  logic [7:0] lane_byte;
  logic [31:0] load_val;

  assign lane_ofs = xaddr_reg[1:0];
  // Both endian modes reduce to one right rotate by the byte offset
  assign rot_amt = {lane_ofs, 3'b000};
  assign rotated = (mem_rdata >> rot_amt) | (mem_rdata << (6'd32 - {1'b0, rot_amt}));
  assign byte_lane = ctrl_reg[`SDT_CTRL_ENDIAN] ? ~lane_ofs : lane_ofs;
  assign lane_byte = mem_rdata[{byte_lane, 3'b000} +: 8];
  assign load_val = byte_reg ? {24'h000000, lane_byte} : rotated;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  logic addr_phase;
  logic [31:0] rd_mux;

  assign addr_phase = hsel & htrans[1] & hready;

  always_comb
  begin
    case (haddr[7:0])
      `SDT_OFS_CTRL: rd_mux = {29'h0, ctrl_reg[2:1], 1'b0};
      `SDT_OFS_INSTR: rd_mux = instr_reg;
      `SDT_OFS_FLAGS: rd_mux = {28'h0, flags_reg};
      `SDT_OFS_BASE: rd_mux = base_val_reg;
      `SDT_OFS_OFFSET: rd_mux = offset_val_reg;
      `SDT_OFS_SRC: rd_mux = src_reg;
      `SDT_OFS_PC: rd_mux = pc_reg;
      `SDT_OFS_STATUS: rd_mux = {25'h0, status_reg[6:1], state_reg != ST_IDLE};
      `SDT_OFS_RESULT: rd_mux = result_reg;
      `SDT_OFS_NEWBASE: rd_mux = newbase_reg;
      `SDT_OFS_ADDR: rd_mux = xaddr_reg;
      `SDT_OFS_CYCLES: rd_mux = {28'h0, cycles_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        wr_addr_reg <= haddr[7:0];
      if (addr_phase & ~hwrite)
        hrdata_reg <= rd_mux;
      hready_reg <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= 3'h0;
      instr_reg <= 32'h0000_0000;
      flags_reg <= 4'h0;
      base_val_reg <= 32'h0000_0000;
      offset_val_reg <= 32'h0000_0000;
      src_reg <= 32'h0000_0000;
      pc_reg <= 32'h0000_0000;
    end
    else if (ce && wr_pend_reg)
    begin
      case (wr_addr_reg)
        `SDT_OFS_CTRL: ctrl_reg <= {hwdata[2:1], 1'b0};
        `SDT_OFS_INSTR: instr_reg <= hwdata;
        `SDT_OFS_FLAGS: flags_reg <= hwdata[3:0];
        `SDT_OFS_BASE: base_val_reg <= hwdata;
        `SDT_OFS_OFFSET: offset_val_reg <= hwdata;
        `SDT_OFS_SRC: src_reg <= hwdata;
        `SDT_OFS_PC: pc_reg <= hwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      mem_reg <= '0;
      status_reg <= 7'h00;
      result_reg <= 32'h0000_0000;
      newbase_reg <= 32'h0000_0000;
      xaddr_reg <= 32'h0000_0000;
      abort_pulse_reg <= 1'b0;
      pc_dest_reg <= 1'b0;
      load_reg <= 1'b0;
      byte_reg <= 1'b0;
      aborted_reg <= 1'b0;
    end
    else if (ce)
    begin
      abort_pulse_reg <= 1'b0;
      mem_reg.req <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          mem_reg.cyc <= CYC_IDLE;
          if (go)
          begin
            status_reg <= 7'h00;
            aborted_reg <= 1'b0;
            if (!cond_pass(ins.cond, flags_reg) || illegal)
            begin
              status_reg[`SDT_ST_DONE] <= 1'b1;
              status_reg[`SDT_ST_SKIP] <= ~illegal;
              status_reg[`SDT_ST_ILLEGAL] <= illegal;
            end
            else
            begin
              state_reg <= ST_XFER;
              mem_reg.req <= 1'b1;
              mem_reg.write <= ~ins.load;
              mem_reg.byte_sel <= ins.byte_sel;
              mem_reg.user <= user_req;
              mem_reg.cyc <= CYC_N;
              mem_reg.addr <= xfer_addr;
              mem_reg.wdata <= ins.load ? 32'h0000_0000 : store_data;
              xaddr_reg <= xfer_addr;
              newbase_reg <= wb_req ? modified : base_eff;
              status_reg[`SDT_ST_WBACK] <= wb_req;
              status_reg[`SDT_ST_USER] <= user_req;
              pc_dest_reg <= ins.rd == `SDT_PC_REG;
              load_reg <= ins.load;
              byte_reg <= ins.byte_sel;
            end
          end
        end
        ST_XFER:
        begin
          // Base write-back stands even when aborted, software unwinds it
          if (mem_abort)
          begin
            aborted_reg <= 1'b1;
            abort_pulse_reg <= 1'b1;
            status_reg[`SDT_ST_ABORT] <= 1'b1;
          end
          else if (load_reg)
            result_reg <= load_val;
          state_reg <= load_reg ? ST_INT : ST_STN;
          mem_reg.cyc <= load_reg ? CYC_I : CYC_N;
        end
        ST_INT:
        begin
          state_reg <= (pc_dest_reg && !aborted_reg) ? ST_REFN : ST_SEQ;
          mem_reg.cyc <= (pc_dest_reg && !aborted_reg) ? CYC_N : CYC_S;
        end
        ST_REFN:
        begin
          state_reg <= ST_REFS;
          mem_reg.cyc <= CYC_S;
        end
        ST_REFS:
        begin
          state_reg <= ST_SEQ;
          mem_reg.cyc <= CYC_S;
        end
        ST_SEQ, ST_STN:
        begin
          state_reg <= ST_IDLE;
          mem_reg.cyc <= CYC_IDLE;
          status_reg[`SDT_ST_DONE] <= 1'b1;
        end
        default:
        begin
          state_reg <= ST_IDLE;
          mem_reg.cyc <= CYC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= 4'h0;
      cycles_reg <= 4'h0;
    end
    else if (ce)
    begin
      if (state_reg == ST_IDLE)
        cnt_reg <= 4'h0;
      else
        cnt_reg <= cnt_reg + 4'h1;
      if (state_reg == ST_SEQ || state_reg == ST_STN)
        cycles_reg <= cnt_reg + 4'h1;
    end
  end

  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign mem_out = mem_reg;
  assign data_abort = abort_pulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !ce);

  sequence s_start_ok;
    go && cond_pass(ins.cond, flags_reg) && !illegal;
  endsequence

  // Illegal encodings report illegal rather than skipped, so they stay out of this one
  sequence s_start_fail;
    go && !cond_pass(ins.cond, flags_reg) && !illegal;
  endsequence

  AST_COND_SKIP: assert property (s_start_fail |=> !mem_reg.req && state_reg == ST_IDLE
                                  && status_reg[`SDT_ST_SKIP])
    else $error("failed condition still started a transfer");

  AST_ADDR: assert property (s_start_ok |=> mem_reg.addr ==
                             $past(ins.pre ? (ins.up ? base_eff + off_eff : base_eff - off_eff)
                                           : base_eff))
    else $error("transfer address wrong");

  AST_POST_WB: assert property (s_start_ok and !ins.pre |=>
                                newbase_reg == $past(modified) && mem_reg.addr == $past(base_eff))
    else $error("post-index write-back wrong");

  AST_PRE_NOWB: assert property (s_start_ok and (ins.pre && !ins.wback) |=>
                                 newbase_reg == $past(base_eff))
    else $error("pre-index without write-back changed base");

  AST_USER: assert property (s_start_ok |=> mem_reg.user ==
                             $past(!ins.pre && ins.wback && ctrl_reg[`SDT_CTRL_PRIV]))
    else $error("user access flag wrong");

  AST_BYTE_STORE: assert property (mem_reg.req && mem_reg.write && mem_reg.byte_sel |->
                                   mem_reg.wdata[31:8] == {3{mem_reg.wdata[7:0]}})
    else $error("byte store not replicated");

  AST_WORD_STORE: assert property (s_start_ok and (!ins.load && !ins.byte_sel
                                   && ins.rd != `SDT_PC_REG) |=> mem_reg.wdata == $past(src_reg))
    else $error("word store rotated");

  AST_PC_STORE: assert property (s_start_ok and (!ins.load && !ins.byte_sel
                                 && ins.rd == `SDT_PC_REG) |=> mem_reg.wdata == $past(pc_reg) + 32'hC)
    else $error("program counter store value wrong");

  AST_LE_BYTE: assert property (state_reg == ST_XFER && load_reg && byte_reg && !mem_abort
                                && !ctrl_reg[`SDT_CTRL_ENDIAN] && xaddr_reg[1:0] == 2'b01
                                |=> result_reg == {24'h0, $past(mem_rdata[15:8])})
    else $error("little endian byte lane wrong");

  AST_BE_BYTE: assert property (state_reg == ST_XFER && load_reg && byte_reg && !mem_abort
                                && ctrl_reg[`SDT_CTRL_ENDIAN] && xaddr_reg[1:0] == 2'b00
                                |=> result_reg == {24'h0, $past(mem_rdata[31:24])})
    else $error("big endian byte lane wrong");

  AST_ABORT: assert property (state_reg == ST_XFER && mem_abort |=> data_abort
                              ##1 !data_abort)
    else $error("abort not signalled for one cycle");

  AST_STORE_CYC: assert property (s_start_ok and !ins.load |=> mem_reg.cyc == CYC_N
                                  ##1 mem_reg.cyc == CYC_N ##1 status_reg[`SDT_ST_DONE])
    else $error("store cycle sequence wrong");

  AST_LOAD_CYC: assert property (s_start_ok and (ins.load && ins.rd != `SDT_PC_REG) |=>
                                 mem_reg.cyc == CYC_N ##1 mem_reg.cyc == CYC_I
                                 ##1 mem_reg.cyc == CYC_S ##1 cycles_reg == `SDT_CYC_LOAD)
    else $error("load cycle sequence wrong");

endmodule

/* tb/sdt_mem_model.sv */
// Behavioural memory and fault source facing the transfer unit
`timescale 1ns/1ps
module sdt_mem_model (
  // Clock
  input wire logic hclk,
  // Transfer link
  input wire sdt_pkg::sdt_mem_t mem_out,
  output logic [31:0] mem_rdata,
  output logic mem_abort,
  // Bench control
  input wire logic big,
  input wire logic fault_en
);
  import sdt_pkg::*;
  logic [31:0] mem [0:63];
  logic [31:0] last_rd = 32'h0;
  logic [31:0] seen_addr = 32'h0;
  logic [31:0] seen_wdata = 32'h0;
  logic seen_user = 1'b0;
  logic [1:0] lane;

  // Fault only while a transfer is on the link
  assign mem_abort = mem_out.req & fault_en;
  // Released bus shows the inverse of its last word, so stale data cannot pass
  assign mem_rdata = (mem_out.req & ~mem_out.write) ? mem[mem_out.addr[7:2]] : ~last_rd;
  assign lane = big ? ~mem_out.addr[1:0] : mem_out.addr[1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Bench preloads the array, so plain always rather than always_ff
  always @(posedge hclk)
  begin
    if (mem_out.req)
    begin
      last_rd <= mem_rdata;
      seen_addr <= mem_out.addr;
      seen_wdata <= mem_out.wdata;
      seen_user <= mem_out.user;
      if (mem_out.write & ~mem_abort)
      begin
        if (mem_out.byte_sel)
          mem[mem_out.addr[7:2]][8*lane +: 8] <= mem_out.wdata[8*lane +: 8];
        else
          mem[mem_out.addr[7:2]] <= mem_out.wdata;
      end
    end
  end
endmodule

/* tb/testbench.sv */
// Random and corner-case bench for the single data transfer unit
`timescale 1ns/1ps
`include "sdt_params.svh"
module testbench;
  import sdt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, data_abort, mem_abort, big, fault_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata, rv, r;
  sdt_mem_t mem_out;
  int n_errors = 0;
  int num_checks = 0;
  int n_abt = 0;
  int n_n, n_s, n_i, i, c;
  logic [31:0] shadow [0:63];
  logic [31:0] last_res = 32'h0;

  sdt_unit i_sdt_unit (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_out(mem_out),
    .mem_rdata(mem_rdata), .mem_abort(mem_abort), .data_abort(data_abort));
  sdt_mem_model i_sdt_mem_model (.hclk(hclk), .mem_out(mem_out), .mem_rdata(mem_rdata),
    .mem_abort(mem_abort), .big(big), .fault_en(fault_en));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Counted at the falling edge, clear of the edge where the bench zeroes them
  always @(negedge hclk)
  begin
    if (data_abort === 1'b1) n_abt++;
    if (mem_out.cyc === CYC_N) n_n++;
    if (mem_out.cyc === CYC_S) n_s++;
    if (mem_out.cyc === CYC_I) n_i++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task results;
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  function automatic logic [31:0] mk(input logic [3:0] cd, input logic ro, p, u, b, w, l,
                                     input logic [3:0] n, d, input logic [11:0] o);
    return {cd, 2'b01, ro, p, u, b, w, l, n, d, o};
  endfunction

  function automatic logic cond_ok(input logic [3:0] cd, input logic [3:0] fl);
    case (cd)
      4'h0: return fl[2];
      4'h1: return ~fl[2];
      4'h2: return fl[1];
      4'h3: return ~fl[1];
      default: return 1'b1;
    endcase
  endfunction

  // Immediate-amount shifts; amount 0 means 32 for right shifts and carry rotate for ROR
  function automatic logic [31:0] shf(input logic [31:0] v, input logic [4:0] n,
                                      input logic [1:0] ty, input logic cf);
    logic [63:0] x;
    x = {v, v} >> n;
    case (ty)
      2'h0: return v << n;
      2'h1: return (n == 5'h00) ? 32'h0 : v >> n;
      2'h2: return (n == 5'h00) ? {32{v[31]}} : 32'($signed(v) >>> n);
      default: return (n == 5'h00) ? {cf, v[31:1]} : x[31:0];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run(input logic [31:0] ins, input logic [3:0] fl,
                     input logic [31:0] base, offr, src, pc, input logic bg, pv, flt);
    logic [31:0] b, off, mod, a, d, w, res, st, cy, t;
    logic ok, ill, wb, usr, pcl;
    int k, j, abt0;
    ok = cond_ok(ins[31:28], fl);
    ill = ins[25] & ins[4];
    b = (ins[19:16] == 4'hF) ? pc + 32'h8 : base;
    off = ins[25] ? shf(offr, ins[11:7], ins[6:5], fl[1]) : {20'h0, ins[11:0]};
    mod = ins[23] ? b + off : b - off;
    a = ins[24] ? mod : b;
    wb = ~ins[24] | ins[21];
    usr = ~ins[24] & ins[21] & pv;
    w = shadow[a[7:2]];
    k = bg ? 3 - a[1:0] : a[1:0];
    res = ins[22] ? {24'h0, w[8*k +: 8]} : (w >> 8*a[1:0]) | (w << (32 - 8*a[1:0]));
    d = (ins[15:12] == 4'hF) ? pc + 32'hC : src;
    if (ins[22]) d = {4{d[7:0]}};
    ahb(1'b1, `SDT_OFS_INSTR, ins, t);
    ahb(1'b1, `SDT_OFS_FLAGS, {28'h0, fl}, t);
    ahb(1'b1, `SDT_OFS_BASE, base, t);
    ahb(1'b1, `SDT_OFS_OFFSET, offr, t);
    ahb(1'b1, `SDT_OFS_SRC, src, t);
    ahb(1'b1, `SDT_OFS_PC, pc, t);
    // Mode bits first: the start edge still decodes with the previous mode bits
    ahb(1'b1, `SDT_OFS_CTRL, {29'h0, pv, bg, 1'b0}, t);
    big <= bg;
    fault_en <= flt;
    n_n = 0;
    n_s = 0;
    n_i = 0;
    abt0 = n_abt;
    ahb(1'b1, `SDT_OFS_CTRL, {29'h0, pv, bg, 1'b1}, t);
    st = 32'h0;
    for (j = 0; j < 40 && st[1] !== 1'b1; j++)
      ahb(1'b0, `SDT_OFS_STATUS, 32'h0, st);
    if (!ok || ill)
    begin
      check("skip status", {27'h0, st[4:0]}, {27'h0, ill, ~ill, 3'b010});
      check("skip cycles", 32'(n_n + n_s + n_i), 32'h0);
      return;
    end
    pcl = ins[20] & (ins[15:12] == 4'hF) & ~flt;
    check("status", {25'h0, st[6:0]}, {25'h0, usr, wb, 2'b00, flt, 2'b10});
    check("abort pulses", 32'(n_abt - abt0), {31'h0, flt});
    check("mem addr", i_sdt_mem_model.seen_addr, a);
    check("mem user", {31'h0, i_sdt_mem_model.seen_user}, {31'h0, usr});
    ahb(1'b0, `SDT_OFS_ADDR, 32'h0, t);
    check("addr reg", t, a);
    ahb(1'b0, `SDT_OFS_NEWBASE, 32'h0, t);
    check("new base", t, wb ? mod : b);
    ahb(1'b0, `SDT_OFS_CYCLES, 32'h0, cy);
    if (ins[20])
    begin
      check("cycle types", {8'h0, n_n[7:0], n_s[7:0], n_i[7:0]}, pcl ? 32'h20201 : 32'h10101);
      check("cycle count", cy, pcl ? 32'h5 : 32'h3);
      if (!flt) last_res = res;
      ahb(1'b0, `SDT_OFS_RESULT, 32'h0, t);
      check("load value", t, last_res);
    end
    else
    begin
      check("cycle types", {8'h0, n_n[7:0], n_s[7:0], n_i[7:0]}, 32'h20000);
      check("cycle count", cy, 32'h2);
      check("store data", i_sdt_mem_model.seen_wdata, d);
      if (!flt && ins[22]) shadow[a[7:2]][8*k +: 8] = d[7:0];
      else if (!flt) shadow[a[7:2]] = d;
      check("mem word", i_sdt_mem_model.mem[a[7:2]], shadow[a[7:2]]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, big, fault_en} = 4'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    void'($urandom(32'h9C70D224));
    for (i = 0; i < 64; i++)
    begin
      shadow[i] = $urandom;
      i_sdt_mem_model.mem[i] = shadow[i];
    end
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, 8'h30, 32'hFFFF_FFFF, r);
    ahb(1'b0, 8'h30, 32'h0, r);
    check("unmapped", r, 32'h0);
    // Every lane, both sizes, loads and stores, both byte orders, offset always added
    for (i = 0; i < 32; i++)
      run(mk(4'hE, 1'b0, 1'b1, 1'b1, i[2], 1'b0, i[3], 4'h2, 4'h1, {10'h0, i[1:0]}), 4'h0,
          32'h40, 32'h0, 32'hA1B2_C3D4, 32'h0, i[4], 1'b0, 1'b0);
    run(mk(4'hE, 0, 1, 0, 0, 0, 1, 4'hF, 4'h1, 12'h010), 4'h0, 0, 0, 0, 32'h100, 0, 0, 0);
    run(mk(4'hE, 0, 1, 1, 0, 0, 0, 4'h2, 4'hF, 12'h004), 4'h0, 32'h80, 0, 0, 32'h200, 0, 0, 0);
    run(mk(4'hE, 0, 1, 1, 0, 0, 1, 4'h2, 4'hF, 12'h000), 4'h0, 32'h84, 0, 0, 0, 0, 0, 0);
    run(mk(4'hE, 0, 1, 1, 0, 0, 1, 4'h2, 4'hF, 12'h000), 4'h0, 32'h88, 0, 0, 0, 0, 0, 1);
    run(mk(4'hE, 1, 1, 1, 0, 0, 1, 4'h2, 4'h1, 12'h013), 4'h0, 32'h40, 4, 0, 0, 0, 0, 0);
    run(mk(4'h0, 0, 1, 1, 0, 0, 0, 4'h2, 4'h1, 12'h004), 4'h0, 32'h40, 0, 5, 0, 0, 0, 0);
    run(mk(4'hE, 0, 0, 1, 0, 1, 1, 4'h2, 4'h1, 12'h008), 4'h0, 32'h90, 0, 0, 0, 0, 1, 0);
    for (i = 0; i < 200; i++)
    begin
      rv = $urandom;
      c = $urandom_range(0, 5);
      // Program counter base never writes back; offset register is never the base
      run(mk(c > 3 ? 4'hE : c[3:0], rv[0], rv[1] | (rv[9:6] == 4'hF), rv[2], rv[3],
             rv[4] & (rv[9:6] != 4'hF), rv[5], rv[9:6], rv[13:10],
             rv[0] ? {rv[25:21], rv[15:14], 1'b0, (rv[9:6] == 4'h3) ? 4'h4 : 4'h3} : rv[25:14]),
          rv[29:26], $urandom, $urandom, $urandom, $urandom, rv[30], rv[31],
          $urandom_range(0, 7) == 0);
    end
    results();
  end

  initial
  begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    results();
  end
endmodule
